// [rtl/bms_pkg.sv]
// Purpose: Types shared by the boost mode sequencer.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Numbers live in bms_regs.svh.
package bms_pkg;

  // One-hot sequencer states
  typedef enum logic [8:0] {
    BMS_SHUTDOWN  = 9'h001,
    BMS_PASSTHRU  = 9'h002,
    BMS_LINEAR_CHARGE_PHASE_ONE      = 9'h004,
    BMS_LINEAR_CHARGE_PHASE_TWO      = 9'h008,
    BMS_STARTUP   = 9'h010,
    BMS_SOFTSTART = 9'h020,
    BMS_BOOST     = 9'h040,
    BMS_BYPASS    = 9'h080,
    BMS_FAULT     = 9'h100
  } bms_state_e;

  // Pins and analogue comparator levels entering the sequencer
  typedef struct packed {
    logic enable;
    logic forced_passthru_select_n;
    logic output_level_select;
    logic undervoltage_lockout_ok;
    logic linear_charge_phase_one_done;
    logic linear_charge_phase_two_done;
    logic vout_reached;
    logic vin_above_target;
    logic overcurrent_guard;
    logic temp_hot;
    logic temp_cool;
  } bms_sense_s;

  // Controls driven to the power stage
  typedef struct packed {
    logic       bypass_switch_on;
    logic       limit_1a;
    logic       limit_2a;
    logic       switching_en;
    logic       switch_on_allow;
    logic       path_hiz;
    logic       discharge_on;
    logic       target_high;
    logic [7:0] ref_ramp;
  } bms_drive_s;

endpackage : bms_pkg

// [rtl/bms_regs.svh]
// Purpose: Offsets, field positions, reset values and timing figures
//          for the boost mode sequencer.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Definitions only.
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

// Register byte offsets
`define BMS_CTRL_OFS        4'h0
`define BMS_STATUS_OFS      4'h4
`define BMS_FAULTCNT_OFS    4'h8

// Control register fields and reset value
`define BMS_CTRL_RESTART_BIT   0
`define BMS_CTRL_DISCHG_BIT    1
`define BMS_CTRL_RST           2'h3

// Status register fields
`define BMS_STAT_STATE_LSB     0
`define BMS_STAT_PG_BIT        16
`define BMS_STAT_OT_BIT        17
`define BMS_STAT_OCP_BIT       18
`define BMS_STAT_LVL_BIT       19

// Clock period and timebase
`define BMS_CLK_PERIOD_NS   5
`define BMS_TICK_NS         1000
`define BMS_TICK_CYC        (`BMS_TICK_NS / `BMS_CLK_PERIOD_NS)

// Sequencer times in microseconds (one timebase tick each)
`define BMS_LINEAR_CHARGE_PHASE_TWO_TMO_US     1024
`define BMS_SS_TMO_US       2000
`define BMS_RESTART_US      1000
`define BMS_HOST_BYP_DLY_US 60

`endif

// [rtl/bms_sequencer.sv]
// Purpose: Mode decode and startup sequencer for a boost regulator with
//          bypass, with power-good flag and Avalon-MM status/control.
// Assumes: 200 MHz clock; all sense inputs are asynchronous levels.
// Notes:   Timeouts run on a 1 us tick derived from the clock.
`timescale 1ns/1ps
`include "bms_regs.svh"

module bms_sequencer
  import bms_pkg::*;
#(
  parameter int unsigned LINEAR_CHARGE_PHASE_TWO_TMO_US = `BMS_LINEAR_CHARGE_PHASE_TWO_TMO_US,
  parameter int unsigned SS_TMO_US   = `BMS_SS_TMO_US,
  parameter int unsigned RESTART_US  = `BMS_RESTART_US,
  parameter int unsigned TICK_CYC    = `BMS_TICK_CYC
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // Pins and comparator levels
  input  wire bms_sense_s  sense,
  // Power stage controls
  output bms_drive_s       drive,
  // Open-drain power-good: output level and enable
  output logic             power_ok_flag_o,
  output logic             power_ok_flag_oe,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  localparam int SW = $bits(bms_sense_s);

  // Register decode, shared by read mux and write path
  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ------------------------------------------------------------------
  // Input synchronisers: three stages, change accepted when 2 and 3 agree
  // ------------------------------------------------------------------
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync3_q;
  logic [SW-1:0] filt_q;
  bms_sense_s    sn;

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      // Stage one feeds stage two only, to keep metastability contained
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          filt_q[gi]  <= 1'b0;
        end else if (clk_en) begin
          sync1_q[gi] <= sense[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            filt_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  assign sn = bms_sense_s'(filt_q);

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  bms_state_e  st_q;
  bms_state_e  st_d;
  logic [7:0]  tick_cnt_q;
  logic        tick;
  logic [10:0] tmr_q;
  logic        ot_latch_q;
  logic        ocp_hold_q;
  logic        pg_q;
  logic [7:0]  ramp_q;
  logic [1:0]  ctrl_q;
  logic [15:0] fault_cnt_q;
  logic        ack_q;
  logic        req;
  logic        auto_mode;

  // Mode decode from the two select pins; with enable low the select
  // level is ignored, so a host may park it either way while off
  assign auto_mode = sn.enable & sn.forced_passthru_select_n;

  // Fixed timebase: one tick per microsecond
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (tick) begin
        tick_cnt_q <= 8'h00;
      end else begin
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end
    end
  end

  assign tick = (tick_cnt_q == 8'(TICK_CYC - 1));

  // State timer: restarts on every state entry so no stale time leaks
  // Saturates, so a long stay still reads as overdue and never as fresh
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tmr_q <= 11'h000;
    end else if (clk_en) begin
      if (st_d != st_q) begin
        tmr_q <= 11'h000;
      end else if (tick && tmr_q != 11'h7ff) begin
        tmr_q <= tmr_q + 11'h001;
      end
    end
  end

  // Next-state logic
  always_comb begin
    st_d = st_q;
    case (st_q)
      BMS_SHUTDOWN: begin
        if (auto_mode && sn.undervoltage_lockout_ok) begin
          st_d = BMS_LINEAR_CHARGE_PHASE_ONE;
        end
      end
      BMS_PASSTHRU: begin
        if (auto_mode && sn.undervoltage_lockout_ok) begin
          st_d = BMS_LINEAR_CHARGE_PHASE_ONE;
        end else if (auto_mode) begin
          st_d = BMS_SHUTDOWN;
        end
      end
      BMS_LINEAR_CHARGE_PHASE_ONE: begin
        if (sn.linear_charge_phase_one_done) begin
          st_d = BMS_LINEAR_CHARGE_PHASE_TWO;
        end
      end
      BMS_LINEAR_CHARGE_PHASE_TWO: begin
        if (tmr_q >= 11'(LINEAR_CHARGE_PHASE_TWO_TMO_US)) begin
          st_d = BMS_FAULT;
        end else if (sn.linear_charge_phase_two_done) begin
          st_d = BMS_STARTUP;
        end
      end
      BMS_STARTUP: begin
        st_d = BMS_SOFTSTART;
      end
      BMS_SOFTSTART: begin
        if (tmr_q >= 11'(SS_TMO_US)) begin
          st_d = BMS_FAULT;
        end else if (sn.vout_reached) begin
          st_d = BMS_BOOST;
        end
      end
      BMS_BOOST: begin
        if (sn.vin_above_target) begin
          st_d = BMS_BYPASS;
        end
      end
      BMS_BYPASS: begin
        if (!sn.vin_above_target) begin
          st_d = BMS_BOOST;
        end
      end
      BMS_FAULT: begin
        if (tmr_q >= 11'(RESTART_US) && ctrl_q[`BMS_CTRL_RESTART_BIT]) begin
          st_d = BMS_LINEAR_CHARGE_PHASE_ONE;
        end
      end
      default: begin
        st_d = BMS_SHUTDOWN;
      end
    endcase
    // Pin decode overrides the sequence; supply loss drops to shutdown
    if (!sn.enable) begin
      st_d = BMS_SHUTDOWN;
    end else if (!sn.forced_passthru_select_n) begin
      st_d = BMS_PASSTHRU;
    end else if (!sn.undervoltage_lockout_ok) begin
      st_d = BMS_SHUTDOWN;
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= BMS_SHUTDOWN;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Over-temperature latch with hysteresis between the two comparators
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ot_latch_q <= 1'b0;
    end else if (clk_en) begin
      if (sn.temp_hot) begin
        ot_latch_q <= 1'b1;
      end else if (sn.temp_cool) begin
        ot_latch_q <= 1'b0;
      end
    end
  end

  // Overcurrent hold: registered copy of the guard, released one clock after current is below limit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ocp_hold_q <= 1'b0;
    end else if (clk_en) begin
      ocp_hold_q <= sn.overcurrent_guard;
    end
  end

  // Power-good: rises on soft-start completion, held in regulation
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pg_q <= 1'b0;
    end else if (clk_en) begin
      if (st_q == BMS_SOFTSTART && st_d == BMS_BOOST) begin
        pg_q <= 1'b1;
      end else if (st_d != BMS_BOOST && st_d != BMS_BYPASS) begin
        pg_q <= 1'b0;
      end
    end
  end

  // Soft-start reference ramp, saturating so it never wraps to zero
  // Limitation: one step per tick, so a full ramp takes 255 ticks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ramp_q <= 8'h00;
    end else if (clk_en) begin
      if (st_q != BMS_SOFTSTART) begin
        ramp_q <= (st_q == BMS_BOOST || st_q == BMS_BYPASS) ? 8'hff : 8'h00;
      end else if (tick && ramp_q != 8'hff) begin
        ramp_q <= ramp_q + 8'h01;
      end
    end
  end

  // Fault counter for software, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fault_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (st_d == BMS_FAULT && st_q != BMS_FAULT &&
          fault_cnt_q != 16'hffff) begin
        fault_cnt_q <= fault_cnt_q + 16'h0001;
      end
    end
  end

  // Power stage controls, registered so glitches never reach the switches
  // Cost: every control lags its source by one clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      drive <= '0;
    end else if (clk_en) begin
      drive.bypass_switch_on <= (st_q == BMS_PASSTHRU) ||
                                (st_q == BMS_BYPASS && !ot_latch_q);
      drive.limit_1a         <= (st_q == BMS_LINEAR_CHARGE_PHASE_ONE);
      drive.limit_2a         <= (st_q == BMS_LINEAR_CHARGE_PHASE_TWO);
      drive.switching_en     <= (st_q == BMS_SOFTSTART ||
                                 st_q == BMS_BOOST) && !ot_latch_q;
      drive.switch_on_allow  <= !sn.overcurrent_guard && !ocp_hold_q;
      drive.path_hiz         <= (st_q == BMS_FAULT ||
                                 st_q == BMS_SHUTDOWN);
      drive.discharge_on     <= !sn.enable &&
                                ctrl_q[`BMS_CTRL_DISCHG_BIT];
      drive.target_high      <= sn.output_level_select;
      drive.ref_ramp         <= ramp_q;
    end
  end

  // Open-drain power-good: pull low unless good, no fault, no overcurrent, not hot
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_ok_flag_oe <= 1'b1;
    end else if (clk_en) begin
      power_ok_flag_oe <= !(pg_q && st_q != BMS_FAULT && !ocp_hold_q &&
                            !ot_latch_q);
    end
  end

  assign power_ok_flag_o = 1'b0;

  // ------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the access completes
  // ------------------------------------------------------------------
  // While the clock enable is low nothing can complete, so the master
  // is kept waiting rather than shown an access that never landed
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~(ack_q & clk_en);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= req & ~ack_q;
    end
  end

  // Control register write, on the completing edge only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `BMS_CTRL_RST;
    end else if (clk_en) begin
      if (avs_write && ack_q && avs_byteenable[0] &&
          reg_hit(avs_address, `BMS_CTRL_OFS)) begin
        ctrl_q <= avs_writedata[1:0];
      end
    end
  end

  // Read data captured during the wait cycle; unmapped reads give zero
  // Capturing early keeps readdata a flip-flop output at completion
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (avs_read && !ack_q) begin
        avs_readdata <= 32'h0000_0000;
        if (reg_hit(avs_address, `BMS_CTRL_OFS)) begin
          avs_readdata[1:0] <= ctrl_q;
        end else if (reg_hit(avs_address, `BMS_STATUS_OFS)) begin
          avs_readdata[8:0]                <= st_q;
          avs_readdata[`BMS_STAT_PG_BIT]   <= !power_ok_flag_oe;
          avs_readdata[`BMS_STAT_OT_BIT]   <= ot_latch_q;
          avs_readdata[`BMS_STAT_OCP_BIT]  <= ocp_hold_q;
          avs_readdata[`BMS_STAT_LVL_BIT]  <= sn.output_level_select;
        end else if (reg_hit(avs_address, `BMS_FAULTCNT_OFS)) begin
          avs_readdata[15:0] <= fault_cnt_q;
        end
      end
    end
  end

endmodule // bms_sequencer

// [sim/bms_host_model.sv]
// Purpose: Host logic driving the enable and bypass-select pins.
// Assumes: Settle delay counted in cycles of the shared clock.
// Notes:   Extra delay lets the bench make the host slow.
`timescale 1ns/1ps
module bms_host_model #(
  parameter int DLY = 120
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       go_en,
  input  wire logic       go_auto,
  input  wire logic       idle_sel,
  input  wire logic [7:0] extra,
  output logic            en_q,
  output logic            sel_n_q
);
  logic [15:0] cnt_q;
  // Time since enable rose; saturates so it never wraps
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt_q <= 16'h0;
    else if (!en_q) cnt_q <= 16'h0;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h1;
  end
  // Select may only rise once enable has settled; the parked level is
  // dropped on the very edge that raises enable, so the two never overlap
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_q    <= 1'b0;
      sel_n_q <= 1'b0;
    end else begin
      en_q    <= go_en;
      sel_n_q <= go_en ? go_auto && (cnt_q > DLY + extra) : idle_sel;
    end
  end
endmodule // bms_host_model

// [sim/bms_sequencer_properties.sv]
// Purpose: Concurrent checks on the sequencer's pins.
// Assumes: A held input reaches the drive pins within 8 edges.
// Notes:   Clock enable is taken as high throughout.
`timescale 1ns/1ps
module bms_sequencer_properties
  import bms_pkg::*;
#(
  parameter int unsigned LINEAR_CHARGE_PHASE_TWO_TMO_US = 1024,
  parameter int unsigned TICK_CYC    = 200
) (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire bms_sense_s sense,
  input wire bms_drive_s drive,
  input wire logic       power_ok_flag_o,
  input wire logic       power_ok_flag_oe
);
  // Longest legal stay at 2A, with slack for the tick phase
  localparam int LIM = (LINEAR_CHARGE_PHASE_TWO_TMO_US + 2) * TICK_CYC + 4;
  logic [31:0] linear_charge_phase_two_cnt_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Cycles with the 2A limit on, restarted on each entry
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) linear_charge_phase_two_cnt_q <= 32'h0;
    else if (!drive.limit_2a) linear_charge_phase_two_cnt_q <= 32'h0;
    else linear_charge_phase_two_cnt_q <= linear_charge_phase_two_cnt_q + 32'h1;
  end
  AST_OFF_IDLE:
    assert property (!sense.enable [*8] |-> !drive.switching_en &&
      !drive.bypass_switch_on && drive.path_hiz)
    else $error("power stage active while disabled");
  AST_OFF_DISCHARGE:
    assert property (!sense.enable [*8] |-> drive.discharge_on)
    else $error("no discharge while disabled");
  AST_PASSTHRU:
    assert property ((sense.enable && !sense.forced_passthru_select_n)
      [*8] |-> drive.bypass_switch_on && !drive.switching_en &&
      !drive.limit_1a && !drive.limit_2a)
    else $error("pass-through not clean");
  AST_HIZ_FLAG:
    assert property (sense.enable [*8] ##0 drive.path_hiz |->
      power_ok_flag_oe)
    else $error("good flag released in fault");
  AST_OD_LOW:
    assert property (power_ok_flag_o == 1'b0)
    else $error("open-drain pin driven high");
  AST_HOT_FLAG:
    assert property (sense.temp_hot [*8] |-> power_ok_flag_oe)
    else $error("good flag released while hot");
  AST_HOT_OFF:
    assert property (sense.temp_hot [*8] |-> !drive.switching_en)
    else $error("switching while hot");
  AST_OC_HOLD:
    assert property (sense.overcurrent_guard [*8] |->
      !drive.switch_on_allow)
    else $error("switch-on allowed in overcurrent");
  AST_GOOD_SRC:
    assert property ($fell(power_ok_flag_oe) |-> !drive.path_hiz &&
      !drive.limit_1a && !drive.limit_2a)
    else $error("good flag released before regulation");
  AST_LEVEL:
    assert property ($stable(sense.output_level_select) [*8] ##0
      drive.switching_en |->
      drive.target_high == sense.output_level_select)
    else $error("target level does not follow select");
  AST_LINEAR_CHARGE_PHASE_TWO_TMO:
    assert property (linear_charge_phase_two_cnt_q <= LIM)
    else $error("second charge phase overstayed");
  COV_GOOD: cover property ($fell(power_ok_flag_oe));
  COV_FAULT: cover property (drive.limit_2a ##1 drive.path_hiz);
  COV_BYP: cover property ($rose(drive.bypass_switch_on));
endmodule // bms_sequencer_properties

bind bms_sequencer bms_sequencer_properties #(
  .LINEAR_CHARGE_PHASE_TWO_TMO_US(LINEAR_CHARGE_PHASE_TWO_TMO_US), .TICK_CYC(TICK_CYC)) u_props (
  .clock(clock), .arst_n(arst_n), .sense(sense), .drive(drive),
  .power_ok_flag_o(power_ok_flag_o),
  .power_ok_flag_oe(power_ok_flag_oe));

// [sim/bms_sequencer_tb.sv]
// Purpose: Self-checking bench for the boost mode sequencer.
// Assumes: Two cycles per tick and shortened timeouts.
// Notes:   State is polled through the status register.
`timescale 1ns/1ps
`include "bms_regs.svh"
module bms_sequencer_tb;
  import bms_pkg::*;
  localparam int TK = 2;
  bms_sense_s  s;
  bms_sense_s  sense;
  bms_drive_s  drive;
  logic        clock;
  logic        arst_n;
  logic        go_en;
  logic        go_auto;
  logic        idle_sel;
  logic [7:0]  extra;
  logic        en;
  logic        sel_n;
  logic        pg_oe;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] q;
  logic [7:0]  r;
  logic [1:0]  m;
  logic        lvl;
  int          k;
  int          err_count;
  int          n_checks;
  int          seed;
  // Host pins override the bench's copy of the sense word
  always_comb begin
    sense = s;
    sense.enable = en;
    sense.forced_passthru_select_n = sel_n;
  end
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  bms_host_model #(.DLY(`BMS_HOST_BYP_DLY_US * TK)) host (
    .clock(clock), .arst_n(arst_n), .go_en(go_en), .go_auto(go_auto),
    .idle_sel(idle_sel), .extra(extra), .en_q(en), .sel_n_q(sel_n));
  bms_sequencer #(.LINEAR_CHARGE_PHASE_TWO_TMO_US(12), .SS_TMO_US(20), .RESTART_US(6),
    .TICK_CYC(TK)) dut (
    .clock(clock), .arst_n(arst_n), .clk_en(1'b1), .sense(sense),
    .drive(drive), .power_ok_flag_o(), .power_ok_flag_oe(pg_oe),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  function automatic bms_state_e mode_of(input logic e, input logic a);
    if (!e) return BMS_SHUTDOWN;
    return a ? BMS_LINEAR_CHARGE_PHASE_ONE : BMS_PASSTHRU;
  endfunction
  task automatic print_verdict;
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tmo;
    err_count++;
    $display("ERROR %0t wait timed out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic c, input string msg);
    n_checks++;
    if (c !== 1'b1) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // One bus access; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) tmo();
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Poll the state field under a bounded budget
  task automatic want(input bms_state_e st);
    int i;
    for (i = 0; i < 200; i++) begin
      bus(1'b0, `BMS_STATUS_OFS, 32'h0);
      if (q[8:0] === st) break;
    end
    n_checks++;
    if (i == 200) tmo();
  endtask
  initial begin
    seed = 32'h9a88d203;
    arst_n = 1'b0;
    s = '0;
    {go_en, go_auto, idle_sel, extra} = 11'h0;
    {avs_address, avs_read, avs_write} = 6'h0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    err_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    s.undervoltage_lockout_ok <= 1'b1;
    // Reset value, masked write, read-only status, unmapped hole
    avs_byteenable <= 4'he;
    bus(1'b1, `BMS_CTRL_OFS, 32'h0);
    avs_byteenable <= 4'hf;
    bus(1'b1, `BMS_STATUS_OFS, 32'h0);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, `BMS_CTRL_OFS, 32'h0);
    chk(q === {30'h0, `BMS_CTRL_RST}, "ctrl value");
    bus(1'b0, 4'hc, 32'h0);
    chk(q === 32'h0, "unmapped read");
    // Every pin combination, fixed first then random
    for (k = 0; k < 8; k++) begin
      m = (k < 4) ? k[1:0] : 2'($random(seed));
      go_en <= m[1];
      go_auto <= m[0];
      idle_sel <= m[0];
      extra <= 8'($random(seed));
      want(mode_of(m[1], m[0]));
      chk(drive.discharge_on === ~m[1], "discharge");
      chk(drive.bypass_switch_on === (m == 2'h2), "pass pin");
    end
    go_en <= 1'b1;
    go_auto <= 1'b1;
    want(BMS_LINEAR_CHARGE_PHASE_ONE);
    chk(drive.limit_1a === 1'b1, "1A limit");
    s.linear_charge_phase_one_done <= 1'b1;
    want(BMS_LINEAR_CHARGE_PHASE_TWO);
    chk(drive.limit_2a && !drive.limit_1a, "2A limit");
    s.linear_charge_phase_two_done <= 1'b1;
    want(BMS_SOFTSTART);
    r = drive.ref_ramp;
    repeat (3 * TK) @(posedge clock);
    chk(drive.switching_en && drive.ref_ramp > r, "ramp");
    s.vout_reached <= 1'b1;
    want(BMS_BOOST);
    repeat (2) @(posedge clock);
    chk(pg_oe === 1'b0, "good");
    lvl = 1'($random(seed));
    for (k = 0; k < 2; k++) begin
      s.output_level_select <= lvl;
      repeat (8) @(posedge clock);
      chk(drive.target_high === lvl, "level");
      lvl = ~lvl;
    end
    s.vin_above_target <= 1'b1;
    want(BMS_BYPASS);
    chk(drive.bypass_switch_on === 1'b1, "follow input");
    s.vin_above_target <= 1'b0;
    want(BMS_BOOST);
    s.overcurrent_guard <= 1'b1;
    repeat (8) @(posedge clock);
    chk(!drive.switch_on_allow && pg_oe, "oc hold");
    s.overcurrent_guard <= 1'b0;
    repeat (8) @(posedge clock);
    chk(drive.switch_on_allow && !pg_oe, "oc free");
    // Hot, then neither threshold, then cool
    for (k = 0; k < 3; k++) begin
      s.temp_hot <= (k == 0);
      s.temp_cool <= (k == 2);
      repeat (8) @(posedge clock);
      chk(pg_oe === (k < 2), "hot flag");
      chk(drive.switching_en === (k == 2), "hot latch");
    end
    s.temp_cool <= 1'b0;
    go_en <= 1'b0;
    s.vout_reached <= 1'b0;
    want(BMS_SHUTDOWN);
    go_en <= 1'b1;
    want(BMS_FAULT);
    chk(drive.path_hiz && pg_oe, "fault");
    s.linear_charge_phase_one_done <= 1'b0;
    s.linear_charge_phase_two_done <= 1'b0;
    want(BMS_LINEAR_CHARGE_PHASE_ONE);
    s.linear_charge_phase_one_done <= 1'b1;
    want(BMS_FAULT);
    bus(1'b0, `BMS_FAULTCNT_OFS, 32'h0);
    chk(q[15:0] === 16'h2, "fault count");
    print_verdict();
  end
endmodule // bms_sequencer_tb
